//--- core/sdpc_pin_control.sv
// sdram pin control: turns external port requests into sdram pin cycles,
// data masks, clock enable handling and host bus hand-over.
// assumes the sdram devices and the host share this clock; inputs are synchronous.

// Summary of operation
// - The select output goes low on every sdram command cycle, which for reads and writes means address bits 31:26 equal 000001.
// - Only the processor that masters the bus drives the select pin; a slave leaves it undriven.
// - On a read or write the row strobe is low in the cycle that carries the row address.
// - On a read or write the column strobe is low in the cycle that carries the column address.
// - Other sdram operations are coded on row strobe, column strobe and write enable per the sdram standard.
// - With the column strobe low, write enable is low for a write and high for a read.
// - A high data mask disables the sdram data buffers of its word half.
// - The masks matter only with the column strobe low and stay inactive on reads.
// - A write to an odd word on a 64-bit bus raises the low-word mask.
// - A write raises the high-word mask for an even word access and always on a 32-bit bus.
// - Address bit ten has its own pin so precharge can run while the shared address bus is busy.
// - Clock enable is used to enter and leave self-refresh and suspend.
// - Before granting the bus the master weakly holds clock enable high, or low in self-refresh; a slave holds nothing.
// - On hand-over to a host the master puts the sdram into self-refresh first and then floats its sdram pins.
module sdpc_pin_control (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire sdpc_pkg::sdpc_op_type cmd_op,
   input wire logic [31:0] cmd_addr,
   input wire logic cmd_word_access,
   input wire logic bus_is_32,
   input wire logic is_bus_master,
   input wire logic host_bus_request_n,
   output logic cmd_ready,
   output logic cmd_rejected,
   output logic sdram_space_select_n,
   output logic sdram_space_select_oe,
   output logic ras_n,
   output logic cas_n,
   output logic sdram_write_enable_n,
   output logic low_word_data_mask,
   output logic high_word_data_mask,
   output logic [sdpc_pkg::addr_width-1:0] sdram_addr,
   output logic sdram_addr_bit_ten,
   output logic sdram_clock_enable,
   output logic sdram_pins_oe,
   output logic cke_weak_pull_up,
   output logic cke_weak_pull_down,
   output logic host_bus_grant_n,
   output logic host_bus_grant_oe,
   output logic in_self_refresh,
   output logic in_suspend
);

   typedef struct packed {
      sdpc_pkg::sdpc_state_type state;
      logic ready;
      logic rejected;
      logic sel_n;
      logic [2:0] cmd;
      logic low_mask;
      logic high_mask;
      logic [sdpc_pkg::addr_width-1:0] addr;
      logic a10;
      logic cke;
      logic pins_oe;
      logic pull_up;
      logic pull_down;
      logic grant_n;
      logic grant_oe;
      logic self_ref;
      logic suspend;
      logic pend_write;
      logic pend_odd;
      logic pend_word;
      logic [sdpc_pkg::col_width-1:0] pend_col;
   } sdpc_regs_type;

   localparam sdpc_regs_type regs_reset = '{
      state: sdpc_pkg::sdpc_st_idle,
      ready: 1'b0,
      rejected: 1'b0,
      sel_n: 1'b1,
      cmd: sdpc_pkg::cmd_nop,
      low_mask: 1'b0,
      high_mask: 1'b0,
      addr: sdpc_pkg::addr_reset,
      a10: 1'b0,
      cke: sdpc_pkg::cke_reset,
      pins_oe: 1'b0,
      pull_up: 1'b0,
      pull_down: 1'b0,
      grant_n: 1'b1,
      grant_oe: 1'b0,
      self_ref: 1'b0,
      suspend: 1'b0,
      pend_write: 1'b0,
      pend_odd: 1'b0,
      pend_word: 1'b0,
      pend_col: 10'h000
   };

   sdpc_regs_type r;
   sdpc_regs_type next_r;

   function automatic logic in_sdram_space(input logic [31:0] a);
      in_sdram_space = (a[sdpc_pkg::space_hi:sdpc_pkg::space_lo] == sdpc_pkg::space_match);
   endfunction

   // one cycle with select low and the given strobe code
   function automatic sdpc_regs_type issue(input sdpc_regs_type s, input logic [2:0] code);
      sdpc_regs_type t;
      t = s;
      t.sel_n = 1'b0;
      t.cmd = code;
      issue = t;
   endfunction

   always_comb begin
      logic take;
      logic busy_low_power;
      take = 1'b0;
      busy_low_power = 1'b0;
      next_r = r;
      // default is a deselected nop with masks low
      next_r.sel_n = 1'b1;
      next_r.cmd = sdpc_pkg::cmd_nop;
      next_r.low_mask = 1'b0;
      next_r.high_mask = 1'b0;
      next_r.rejected = 1'b0;
      next_r.ready = 1'b0;
      // a slave never drives the shared sdram pins or the grant
      next_r.pins_oe = is_bus_master && (r.state != sdpc_pkg::sdpc_st_granted);
      next_r.grant_oe = is_bus_master;
      next_r.pull_up = is_bus_master && !r.self_ref;
      next_r.pull_down = is_bus_master && r.self_ref;
      busy_low_power = r.self_ref || r.suspend;
      case (r.state)
         sdpc_pkg::sdpc_st_idle: begin
            if (is_bus_master && !host_bus_request_n) begin
               if (!r.self_ref) begin
                  if (r.suspend) begin
                     next_r.cke = 1'b1;
                     next_r.suspend = 1'b0;
                  end else begin
                     next_r = issue(next_r, sdpc_pkg::cmd_refresh);
                     next_r.cke = 1'b0;
                     next_r.self_ref = 1'b1;
                     next_r.state = sdpc_pkg::sdpc_st_handoff;
                  end
               end else begin
                  next_r.state = sdpc_pkg::sdpc_st_handoff;
               end
            end else if (is_bus_master) begin
               next_r.ready = 1'b1;
               take = cmd_valid && r.ready;
            end
            if (take) begin
               next_r.ready = 1'b0;
               case (cmd_op)
                  sdpc_pkg::sdpc_op_read, sdpc_pkg::sdpc_op_write: begin
                     if (!in_sdram_space(cmd_addr) || busy_low_power) begin
                        next_r.rejected = 1'b1;
                        next_r.ready = 1'b1;
                     end else begin
                        next_r = issue(next_r, sdpc_pkg::cmd_activate);
                        next_r.addr = cmd_addr[sdpc_pkg::row_lo +: sdpc_pkg::addr_width];
                        next_r.a10 = cmd_addr[sdpc_pkg::row_lo + sdpc_pkg::bit_ten];
                        next_r.pend_write = (cmd_op == sdpc_pkg::sdpc_op_write);
                        next_r.pend_odd = cmd_addr[sdpc_pkg::odd_bit];
                        next_r.pend_word = cmd_word_access;
                        next_r.pend_col = cmd_addr[sdpc_pkg::col_lo +: sdpc_pkg::col_width];
                        next_r.state = sdpc_pkg::sdpc_st_column;
                     end
                  end
                  sdpc_pkg::sdpc_op_refresh: begin
                     // refresh leaves the shared address bus alone
                     if (busy_low_power) begin
                        next_r.rejected = 1'b1;
                     end else begin
                        next_r = issue(next_r, sdpc_pkg::cmd_refresh);
                     end
                     next_r.ready = 1'b1;
                  end
                  sdpc_pkg::sdpc_op_precharge: begin
                     if (busy_low_power) begin
                        next_r.rejected = 1'b1;
                     end else begin
                        // precharge all uses bit ten high
                        next_r = issue(next_r, sdpc_pkg::cmd_precharge);
                        next_r.a10 = 1'b1;
                     end
                     next_r.ready = 1'b1;
                  end
                  sdpc_pkg::sdpc_op_mode_set: begin
                     if (busy_low_power) begin
                        next_r.rejected = 1'b1;
                     end else begin
                        next_r = issue(next_r, sdpc_pkg::cmd_mode_set);
                        next_r.addr = cmd_addr[sdpc_pkg::addr_width-1:0];
                        next_r.a10 = cmd_addr[sdpc_pkg::bit_ten];
                     end
                     next_r.ready = 1'b1;
                  end
                  sdpc_pkg::sdpc_op_self_refresh: begin
                     if (busy_low_power) begin
                        next_r.rejected = 1'b1;
                     end else begin
                        // refresh code with clock enable low
                        next_r = issue(next_r, sdpc_pkg::cmd_refresh);
                        next_r.cke = 1'b0;
                        next_r.self_ref = 1'b1;
                     end
                     next_r.ready = 1'b1;
                  end
                  sdpc_pkg::sdpc_op_suspend: begin
                     if (busy_low_power) begin
                        next_r.rejected = 1'b1;
                     end else begin
                        next_r.cke = 1'b0;
                        next_r.suspend = 1'b1;
                     end
                     next_r.ready = 1'b1;
                  end
                  sdpc_pkg::sdpc_op_wake: begin
                     if (!busy_low_power) begin
                        next_r.rejected = 1'b1;
                        next_r.ready = 1'b1;
                     end else begin
                        // raise clock enable, one nop after
                        next_r.cke = 1'b1;
                        next_r.self_ref = 1'b0;
                        next_r.suspend = 1'b0;
                        next_r.state = sdpc_pkg::sdpc_st_wake;
                     end
                  end
                  default: begin
                     next_r.rejected = 1'b1;
                     next_r.ready = 1'b1;
                  end
               endcase
            end
         end
         sdpc_pkg::sdpc_st_column: begin
            next_r = issue(next_r, r.pend_write ? sdpc_pkg::cmd_write : sdpc_pkg::cmd_read);
            next_r.addr = {{(sdpc_pkg::addr_width - sdpc_pkg::col_width){1'b0}}, r.pend_col};
            next_r.a10 = 1'b0;
            if (r.pend_write) begin
               next_r.low_mask = !bus_is_32 && r.pend_word && r.pend_odd;
               next_r.high_mask = bus_is_32 || (r.pend_word && !r.pend_odd);
            end
            next_r.state = sdpc_pkg::sdpc_st_idle;
            next_r.ready = 1'b1;
         end
         sdpc_pkg::sdpc_st_handoff: begin
            next_r.pins_oe = 1'b0;
            next_r.grant_n = 1'b0;
            next_r.state = sdpc_pkg::sdpc_st_granted;
         end
         sdpc_pkg::sdpc_st_granted: begin
            next_r.pins_oe = 1'b0;
            // grant stands until the host drops its request or this block stops being bus master
            if (host_bus_request_n || !is_bus_master) begin
               next_r.grant_n = 1'b1;
               next_r.state = sdpc_pkg::sdpc_st_idle;
            end
         end
         sdpc_pkg::sdpc_st_wake: begin
            // nop cycle so the first command sees a stable clock
            next_r.state = sdpc_pkg::sdpc_st_idle;
            next_r.ready = 1'b1;
         end
         default: begin
            next_r = regs_reset;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= regs_reset;
      end else begin
         r <= next_r;
      end
   end

   assign cmd_ready = r.ready;
   assign cmd_rejected = r.rejected;
   assign sdram_space_select_n = r.sel_n;
   assign sdram_space_select_oe = r.pins_oe;
   assign ras_n = r.cmd[2];
   assign cas_n = r.cmd[1];
   assign sdram_write_enable_n = r.cmd[0];
   assign low_word_data_mask = r.low_mask;
   assign high_word_data_mask = r.high_mask;
   assign sdram_addr = r.addr;
   assign sdram_addr_bit_ten = r.a10;
   assign sdram_clock_enable = r.cke;
   assign sdram_pins_oe = r.pins_oe;
   assign cke_weak_pull_up = r.pull_up;
   assign cke_weak_pull_down = r.pull_down;
   assign host_bus_grant_n = r.grant_n;
   assign host_bus_grant_oe = r.grant_oe;
   assign in_self_refresh = r.self_ref;
   assign in_suspend = r.suspend;

endmodule

//--- core/sdpc_pkg.sv
// package for the sdram pin control block: command kinds, pin encodings,
// address decode and field positions.
// assumes one 100 MHz clock shared with the sdram devices.
package sdpc_pkg;

   // requested operation from the external port
   typedef enum logic [2:0] {
      sdpc_op_read = 3'h0,
      sdpc_op_write = 3'h1,
      sdpc_op_refresh = 3'h2,
      sdpc_op_precharge = 3'h3,
      sdpc_op_mode_set = 3'h4,
      sdpc_op_self_refresh = 3'h5,
      sdpc_op_suspend = 3'h6,
      sdpc_op_wake = 3'h7
   } sdpc_op_type;

   typedef enum logic [2:0] {
      sdpc_st_idle = 3'h0,
      sdpc_st_column = 3'h1,
      sdpc_st_handoff = 3'h2,
      sdpc_st_granted = 3'h3,
      sdpc_st_wake = 3'h4
   } sdpc_state_type;

   // {row strobe, column strobe, write enable}, all active low
   localparam logic [2:0] cmd_nop = 3'h7;
   localparam logic [2:0] cmd_activate = 3'h3;
   localparam logic [2:0] cmd_read = 3'h5;
   localparam logic [2:0] cmd_write = 3'h4;
   localparam logic [2:0] cmd_precharge = 3'h2;
   localparam logic [2:0] cmd_refresh = 3'h1;
   localparam logic [2:0] cmd_mode_set = 3'h0;

   // sdram space decode
   localparam int space_hi = 31;
   localparam int space_lo = 26;
   localparam logic [5:0] space_match = 6'h01;

   // address field positions within a word address
   localparam int addr_width = 14;
   localparam int row_lo = 11;
   localparam int col_lo = 1;
   localparam int col_width = 10;
   localparam int odd_bit = 0;
   localparam int bit_ten = 10;

   // reset values
   localparam logic [addr_width-1:0] addr_reset = 14'h0000;
   localparam logic cke_reset = 1'b1;
endpackage

//--- test/sdpc_pin_control_chk.sv
// checker for the sdram pin control block: pin cycles tied to their requests.
// assumes it is bound to sdpc_pin_control and sees only its ports.
module sdpc_pin_control_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire sdpc_pkg::sdpc_op_type cmd_op,
   input wire logic [31:0] cmd_addr,
   input wire logic cmd_word_access,
   input wire logic bus_is_32,
   input wire logic is_bus_master,
   input wire logic host_bus_request_n,
   input wire logic cmd_ready,
   input wire logic sdram_space_select_n,
   input wire logic sdram_space_select_oe,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic sdram_write_enable_n,
   input wire logic low_word_data_mask,
   input wire logic high_word_data_mask,
   input wire logic sdram_clock_enable,
   input wire logic sdram_pins_oe,
   input wire logic cke_weak_pull_up,
   input wire logic cke_weak_pull_down,
   input wire logic host_bus_grant_n,
   input wire logic in_self_refresh,
   input wire logic in_suspend
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic take, take_rw, take_wr;
   assign take = cmd_valid && cmd_ready && is_bus_master && host_bus_request_n && !in_self_refresh && !in_suspend;
   assign take_rw = take && cmd_op inside {sdpc_pkg::sdpc_op_read, sdpc_pkg::sdpc_op_write}
      && cmd_addr[31:26] == sdpc_pkg::space_match;
   assign take_wr = take_rw && cmd_op == sdpc_pkg::sdpc_op_write;
   property p_select;
      take_rw |=> !sdram_space_select_n [*2];
   endproperty
   a_select: assert property (p_select)
      else $error("select not low for both cycles of an access");
   property p_row_col;
      take_rw |=> (!ras_n && cas_n) ##1 (ras_n && !cas_n);
   endproperty
   a_row_col: assert property (p_row_col)
      else $error("row then column strobe order broken");
   property p_mask_cas;
      low_word_data_mask || high_word_data_mask |-> !cas_n && ras_n && !sdram_write_enable_n;
   endproperty
   a_mask_cas: assert property (p_mask_cas)
      else $error("data mask high outside a write column cycle");
   property p_lo_mask;
      take_wr && cmd_word_access && cmd_addr[0] && !bus_is_32 |-> ##2 low_word_data_mask;
   endproperty
   a_lo_mask: assert property (p_lo_mask)
      else $error("low mask missing on odd word write");
   property p_hi_mask;
      take_wr && (bus_is_32 || cmd_word_access && !cmd_addr[0]) |-> ##2 high_word_data_mask;
   endproperty
   a_hi_mask: assert property (p_hi_mask)
      else $error("high mask missing on write");
   property p_self;
      take && cmd_op == sdpc_pkg::sdpc_op_self_refresh |=> !sdram_clock_enable && in_self_refresh
         && !ras_n && !cas_n && sdram_write_enable_n;
   endproperty
   a_self: assert property (p_self)
      else $error("self refresh entry without clock enable low");
   property p_grant;
      $fell(host_bus_grant_n) |-> in_self_refresh && !sdram_pins_oe && !sdram_space_select_oe
         && cke_weak_pull_down && !cke_weak_pull_up;
   endproperty
   a_grant: assert property (p_grant)
      else $error("grant given with pins driven or sdram awake");
   property p_slave;
      !is_bus_master ##1 !is_bus_master |-> !sdram_space_select_oe && !cke_weak_pull_up && !cke_weak_pull_down;
   endproperty
   a_slave: assert property (p_slave)
      else $error("slave drives select or holds clock enable");
endmodule

bind sdpc_pin_control sdpc_pin_control_chk chk_u (.*);

//--- test/sdpc_sdram_model.sv
// sdram devices on the pins: decode each command, count column cycles
// that arrive with no open row. assumes pins share the block's clock.
module sdpc_sdram_model (
   input wire logic clock,
   input wire logic sdram_space_select_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic sdram_write_enable_n,
   input wire logic sdram_clock_enable,
   input wire logic sdram_pins_oe,
   output int orphan_count
);
   timeunit 1ns;
   timeprecision 100ps;
   logic row_open = 1'h0;
   int orphans = 0;
   assign orphan_count = orphans;
   // floated pins or a stopped clock carry no command
   always @(posedge clock) begin
      if (sdram_pins_oe && sdram_clock_enable && !sdram_space_select_n) begin
         case ({ras_n, cas_n, sdram_write_enable_n})
            sdpc_pkg::cmd_activate: row_open <= 1'h1;
            sdpc_pkg::cmd_precharge: row_open <= 1'h0;
            sdpc_pkg::cmd_read, sdpc_pkg::cmd_write: if (!row_open) orphans <= orphans + 1;
            default: ;
         endcase
      end
   end
endmodule

//--- test/sdpc_pin_control_test.sv
// testbench for the sdram pin control block: drives requests and host line,
// judges sdram pins. assumes one 100 MHz clock.
module sdpc_pin_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, rst_n, cmd_valid, cmd_word_access, bus_is_32, is_bus_master, host_bus_request_n;
   sdpc_pkg::sdpc_op_type cmd_op;
   logic [31:0] cmd_addr;
   logic [sdpc_pkg::addr_width-1:0] sdram_addr;
   logic cmd_ready, cmd_rejected, sdram_space_select_n, sdram_space_select_oe, ras_n, cas_n;
   logic sdram_write_enable_n, low_word_data_mask, high_word_data_mask, sdram_addr_bit_ten;
   logic sdram_clock_enable, sdram_pins_oe, cke_weak_pull_up, cke_weak_pull_down;
   logic host_bus_grant_n, host_bus_grant_oe, in_self_refresh, in_suspend;
   int bad_count, n_compared, orphan_count;
   sdpc_pin_control dut_u (.*);
   sdpc_sdram_model mem_u (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step;
      @(posedge clock);
      #1;
   endtask
   function automatic logic [3:0] pins;
      return {sdram_space_select_n, ras_n, cas_n, sdram_write_enable_n};
   endfunction
   // returns in the first pin cycle after the request is taken
   task automatic issue(input sdpc_pkg::sdpc_op_type op, input logic [31:0] addr);
      // one edge between calls so valid is never lowered and raised in one step
      step;
      for (int n = 0; n < 20 && cmd_ready !== 1'h1; n++) step;
      cmd_op = op;
      cmd_addr = addr;
      cmd_valid = 1'h1;
      step;
      cmd_valid = 1'h0;
   endtask
   task automatic rw(input sdpc_pkg::sdpc_op_type op, input logic [31:0] a, input logic w, b,
      input logic [1:0] m);
      cmd_word_access = w;
      bus_is_32 = b;
      issue(op, a);
      chk({pins(), sdram_addr_bit_ten, sdram_addr}, {4'h3, a[21], a[24:11]});
      step;
      chk({pins(), sdram_addr_bit_ten, sdram_addr}, {3'h2, op == sdpc_pkg::sdpc_op_read, 1'h0, 4'h0, a[10:1]});
      chk({low_word_data_mask, high_word_data_mask}, m);
      step;
      chk(pins(), 4'hf);
   endtask
   task automatic t_access;
      rw(sdpc_pkg::sdpc_op_write, 32'h0420_0c07, 1'h1, 1'h0, 2'h2);
      rw(sdpc_pkg::sdpc_op_write, 32'h0420_0c06, 1'h1, 1'h0, 2'h1);
      rw(sdpc_pkg::sdpc_op_write, 32'h0420_0c06, 1'h0, 1'h0, 2'h0);
      rw(sdpc_pkg::sdpc_op_write, 32'h0420_0c07, 1'h1, 1'h1, 2'h1);
      rw(sdpc_pkg::sdpc_op_read, 32'h07ff_ffff, 1'h1, 1'h1, 2'h0);
      bus_is_32 = 1'h0;
   endtask
   task automatic t_other;
      issue(sdpc_pkg::sdpc_op_refresh, 32'h0);
      chk(pins(), 4'h1);
      issue(sdpc_pkg::sdpc_op_precharge, 32'h0);
      chk({pins(), sdram_addr_bit_ten}, 5'h05);
      issue(sdpc_pkg::sdpc_op_mode_set, 32'h0000_2c5c);
      chk({pins(), sdram_addr_bit_ten, sdram_addr}, {4'h0, 1'h1, 14'h2c5c});
      issue(sdpc_pkg::sdpc_op_read, 32'h0800_0000);
      chk({cmd_rejected, sdram_space_select_n}, 2'h3);
   endtask
   task automatic t_power;
      issue(sdpc_pkg::sdpc_op_self_refresh, 32'h0);
      chk({pins(), sdram_clock_enable, in_self_refresh}, 6'h05);
      step;
      chk({cke_weak_pull_up, cke_weak_pull_down}, 2'h1);
      issue(sdpc_pkg::sdpc_op_read, 32'h0400_0000);
      chk({cmd_rejected, sdram_space_select_n}, 2'h3);
      issue(sdpc_pkg::sdpc_op_wake, 32'h0);
      chk({sdram_clock_enable, in_self_refresh, pins()}, 6'h2f);
      step;
      chk({cke_weak_pull_up, cke_weak_pull_down}, 2'h2);
      issue(sdpc_pkg::sdpc_op_suspend, 32'h0);
      chk({sdram_clock_enable, in_suspend}, 2'h1);
      issue(sdpc_pkg::sdpc_op_wake, 32'h0);
      chk({sdram_clock_enable, in_suspend}, 2'h2);
      issue(sdpc_pkg::sdpc_op_wake, 32'h0);
      chk(cmd_rejected, 1'h1);
   endtask
   task automatic t_host;
      // suspended sdram must be woken and put into self-refresh before the grant
      issue(sdpc_pkg::sdpc_op_suspend, 32'h0);
      host_bus_request_n = 1'h0;
      for (int n = 0; n < 10 && host_bus_grant_n !== 1'h0; n++) step;
      chk({host_bus_grant_n, sdram_pins_oe, sdram_clock_enable, in_self_refresh, cmd_ready, in_suspend}, 6'h04);
      chk({cke_weak_pull_up, cke_weak_pull_down}, 2'h1);
      host_bus_request_n = 1'h1;
      for (int n = 0; n < 5 && host_bus_grant_n !== 1'h1; n++) step;
      step;
      chk({host_bus_grant_n, sdram_pins_oe, in_self_refresh}, 3'h7);
      // second hand-off while already in self-refresh: no new command, grant follows
      host_bus_request_n = 1'h0;
      for (int n = 0; n < 10 && host_bus_grant_n !== 1'h0; n++) step;
      chk({host_bus_grant_n, sdram_pins_oe, cke_weak_pull_down}, 3'h1);
      host_bus_request_n = 1'h1;
      for (int n = 0; n < 5 && host_bus_grant_n !== 1'h1; n++) step;
      step;
      chk({host_bus_grant_n, sdram_pins_oe, in_self_refresh}, 3'h7);
      issue(sdpc_pkg::sdpc_op_wake, 32'h0);
      chk(sdram_clock_enable, 1'h1);
   endtask
   task automatic t_slave;
      is_bus_master = 1'h0;
      step;
      step;
      chk({cmd_ready, sdram_space_select_oe, cke_weak_pull_up, cke_weak_pull_down, host_bus_grant_oe}, 5'h0);
      is_bus_master = 1'h1;
      step;
      step;
   endtask
   task automatic close_out;
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   initial begin
      bad_count = 0;
      n_compared = 0;
      rst_n = 1'h0;
      cmd_valid = 1'h0;
      cmd_op = sdpc_pkg::sdpc_op_read;
      cmd_addr = 32'h0;
      cmd_word_access = 1'h0;
      bus_is_32 = 1'h0;
      is_bus_master = 1'h1;
      host_bus_request_n = 1'h1;
      repeat (5) @(posedge clock);
      chk({pins(), sdram_clock_enable, host_bus_grant_n, sdram_pins_oe}, 7'h7e);
      #1 rst_n = 1'h1;
      step;
      t_access();
      t_other();
      t_power();
      t_host();
      t_slave();
      chk(orphan_count, 32'h0);
      close_out();
   end
   initial begin
      #20000;
      bad_count++;
      close_out();
   end
endmodule
